// ===== rpos_far_model.sv
// rpos_far_model: ignition control line and main supply as seen by the unit
module rpos_far_model (
   input wire logic clock_in,
   output logic control_out,
   output logic supply_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      control_out = 1'b0;
      supply_out = 1'b1;
   end
   // changes land just after an edge so the unit never samples a moving line
   task automatic level(input logic v);
      @(posedge clock_in);
      control_out <= v;
   endtask
   // impulse command held for n cycles, then released low
   task automatic pulse(input int n);
      level(1'b1);
      repeat (n) @(posedge clock_in);
      control_out <= 1'b0;
   endtask
   task automatic supply(input logic v);
      @(posedge clock_in);
      supply_out <= v;
   endtask
endmodule

// ===== rpos_pkg.sv
// rpos_pkg: constants, modes and carriers of the remote power on/off sequencer
package rpos_pkg;

   // ------------------------------------------------------------
   // clock and timebase
   // ------------------------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int MS_PER_S = 1000;
   localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
   localparam int TW = 19;

   // ------------------------------------------------------------
   // timing figures in seconds, pulse figure in ms, ms counts derived from them
   // ------------------------------------------------------------
   localparam int T1_S = 1;
   localparam int T2_S = 2;
   localparam int T5_S = 5;
   localparam int T60_S = 60;
   localparam int T120_S = 120;
   localparam int T300_S = 300;
   localparam int PULSE_MS_FIG = 250;
   localparam int LONG_PRESS_S = 5;

   localparam logic [TW-1:0] T0_MS = 19'h00000;
   localparam logic [TW-1:0] T1_MS = TW'(T1_S * MS_PER_S);
   localparam logic [TW-1:0] T2_MS = TW'(T2_S * MS_PER_S);
   localparam logic [TW-1:0] T5_MS = TW'(T5_S * MS_PER_S);
   localparam logic [TW-1:0] T60_MS = TW'(T60_S * MS_PER_S);
   localparam logic [TW-1:0] T120_MS = TW'(T120_S * MS_PER_S);
   localparam logic [TW-1:0] T300_MS = TW'(T300_S * MS_PER_S);
   localparam logic [TW-1:0] PULSE_MS = TW'(PULSE_MS_FIG);
   localparam logic [TW-1:0] LONG_MS = TW'(LONG_PRESS_S * MS_PER_S);
   localparam logic [TW-1:0] T_MAX = 19'h7ffff;

   // ------------------------------------------------------------
   // switch positions
   // ------------------------------------------------------------
   localparam logic [3:0] POS_BYPASS = 4'h0;
   localparam logic [3:0] POS_USER = 4'ha;

   // ------------------------------------------------------------
   // carriers and states
   // ------------------------------------------------------------
   typedef struct packed {
      logic [TW-1:0] deb_on;
      logic [TW-1:0] deb_off;
      logic [TW-1:0] startup;
      logic [TW-1:0] hard_off;
   } rpos_timing_t;

   typedef enum logic [2:0] {
      S_OFF, S_DEB_ON, S_STARTUP, S_RUN, S_DEB_OFF, S_FAIL, S_CUT, S_HARD_OFF
   } rpos_state_t;

endpackage

// ===== rpos_sequencer.sv
// rpos_sequencer: remote power on/off sequencer of the power management unit
// Function
// - position 0 is bypass: no debounce, hold or timeout sequencing applied.
// - off request flags the host, then supply is cut after the timeout.
// - positions 6-9 take a 250 ms impulse on the control input as command.
// - positions 6 and 8 start the system from off whenever main supply is present; a cut or hard-off holds until supply drops.
// - positions 8 and 9 hard-off when the impulse exceeds five seconds.
// - asserting edge starts on-debounce: 2/1/5 s per position, zero in 6-9.
// - input stable through on-debounce switches the main supply on.
// - after power-up only a long impulse in 8 and 9 is acted on during the 5 s or 60 s startup hold.
// - after the startup hold, off requests are monitored again.
// - deasserting edge starts off-debounce: 60/5 s per position, zero in 6-9.
// - input stable low through off-debounce asserts power fail to the host.
// - hard-off timeout from power fail: 60/300/120/60 s, zero in position 9.
// - timeout without finished shutdown sends stop, cutting power regardless.
// - position A takes user-programmed timings; B-F are reserved, no timing.
// - the current power fail state is a readable status output.
// - position 0 is bypass for power fail mode; 1-A are remote on/off.
module rpos_sequencer #(
   parameter int MS_CYCLES = rpos_pkg::MS_CYCLES
) (
   input wire logic clock_in,
   input wire logic reset_in,
   input wire logic [3:0] timing_select_switch_in,
   input wire logic control_in,
   input wire logic main_supply_input_in,
   input wire logic host_shutdown_done_in,
   input wire rpos_pkg::rpos_timing_t user_timing_in,
   output logic supply_on_out,
   output logic power_fail_out,
   output logic stop_out
);
   import rpos_pkg::*;

   // ------------------------------------------------------------
   // millisecond timebase
   // ------------------------------------------------------------
   // free running, so an interval may run up to 1 ms short
   logic [31:0] prescale;
   logic [31:0] next_prescale;
   logic ms_tick;
   logic next_ms_tick;

   always_comb begin
      next_ms_tick = 1'b0;
      next_prescale = prescale + 32'h00000001;
      if (prescale >= 32'(MS_CYCLES - 1)) begin
         next_prescale = 32'h00000000;
         next_ms_tick = 1'b1;
      end
   end

   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         prescale <= 32'h00000000;
         ms_tick <= 1'b0;
      end else begin
         prescale <= next_prescale;
         ms_tick <= next_ms_tick;
      end
   end

   // ------------------------------------------------------------
   // timing profile per switch position
   // ------------------------------------------------------------
   function automatic rpos_timing_t profile(input logic [3:0] pos, input rpos_timing_t user);
      rpos_timing_t t;
      t = '0;
      unique case (pos)
         4'h1: t = '{T2_MS, T60_MS, T5_MS, T60_MS};
         4'h2: t = '{T2_MS, T60_MS, T60_MS, T300_MS};
         4'h3: t = '{T2_MS, T60_MS, T60_MS, T120_MS};
         4'h4: t = '{T1_MS, T5_MS, T5_MS, T60_MS};
         4'h5: t = '{T5_MS, T5_MS, T60_MS, T60_MS};
         4'h6, 4'h7, 4'h8: t = '{T0_MS, T0_MS, T60_MS, T60_MS};
         4'h9: t = '{T0_MS, T0_MS, T60_MS, T0_MS};
         POS_USER: t = user;
         default: t = '0;
      endcase
      return t;
   endfunction

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   rpos_state_t state;
   rpos_state_t next_state;
   logic [TW-1:0] time_ms;
   logic [TW-1:0] next_time_ms;
   logic [TW-1:0] press_ms;
   logic [TW-1:0] next_press_ms;
   logic control_q;
   logic next_supply_on;
   logic next_power_fail;
   logic next_stop;
   rpos_timing_t tim;
   logic bypass;
   logic reserved;
   logic pulse_mode;
   logic auto_start;
   logic long_mode;
   logic pulse_event;
   logic long_press;

   always_comb begin
      tim = profile(timing_select_switch_in, user_timing_in);
      bypass = (timing_select_switch_in == POS_BYPASS);
      reserved = (timing_select_switch_in > POS_USER);
      pulse_mode = timing_select_switch_in inside {4'h6, 4'h7, 4'h8, 4'h9};
      auto_start = timing_select_switch_in inside {4'h6, 4'h8};
      long_mode = timing_select_switch_in inside {4'h8, 4'h9};
      pulse_event = pulse_mode && control_q && !control_in && (press_ms >= PULSE_MS);
      long_press = long_mode && control_in && (press_ms >= LONG_MS);
      next_press_ms = '0;
      if (control_in) begin
         next_press_ms = (press_ms == T_MAX) ? press_ms : press_ms + TW'(ms_tick);
      end
      next_time_ms = (time_ms == T_MAX) ? time_ms : time_ms + TW'(ms_tick);
      next_state = state;
      unique case (state)
         S_OFF: begin
            next_time_ms = '0;
            if (auto_start) begin
               next_state = S_STARTUP;
            end else if (pulse_mode) begin
               if (pulse_event) begin
                  next_state = S_STARTUP;
               end
            end else if (control_in && !control_q) begin
               next_state = S_DEB_ON;
            end
         end
         S_DEB_ON: begin
            if (!control_in) begin
               next_state = S_OFF;
            end else if (time_ms >= tim.deb_on) begin
               next_state = S_STARTUP;
               next_time_ms = '0;
            end
         end
         S_STARTUP: begin
            if (time_ms >= tim.startup) begin
               next_state = S_RUN;
            end
         end
         S_RUN: begin
            next_time_ms = '0;
            if (pulse_mode ? pulse_event : !control_in) begin
               next_state = pulse_mode ? S_FAIL : S_DEB_OFF;
            end
         end
         S_DEB_OFF: begin
            if (control_in) begin
               next_state = S_RUN;
            end else if (time_ms >= tim.deb_off) begin
               next_state = S_FAIL;
               next_time_ms = '0;
            end
         end
         S_FAIL: begin
            if (time_ms >= tim.hard_off) begin
               next_state = host_shutdown_done_in ? S_CUT : S_HARD_OFF;
            end
         end
         S_CUT, S_HARD_OFF: begin
            if (!control_in && !auto_start) begin
               next_state = S_OFF;
            end
         end
      endcase
      if (long_press && state inside {S_STARTUP, S_RUN, S_DEB_OFF, S_FAIL}) begin
         next_state = S_HARD_OFF;
      end
      if (bypass || reserved || !main_supply_input_in) begin
         next_state = S_OFF;
      end
      next_supply_on = main_supply_input_in &&
         (bypass || next_state inside {S_STARTUP, S_RUN, S_DEB_OFF, S_FAIL});
      next_power_fail = bypass ? !control_in : (next_state == S_FAIL);
      next_stop = (next_state == S_HARD_OFF);
   end

   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         state <= S_OFF;
         time_ms <= '0;
         press_ms <= '0;
         control_q <= 1'b0;
         supply_on_out <= 1'b0;
         power_fail_out <= 1'b0;
         stop_out <= 1'b0;
      end else begin
         state <= next_state;
         time_ms <= next_time_ms;
         press_ms <= next_press_ms;
         control_q <= control_in;
         supply_on_out <= next_supply_on;
         power_fail_out <= next_power_fail;
         stop_out <= next_stop;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (reset_in);

   a_bypass_idle: assert property (bypass |=> state == S_OFF && !stop_out)
      else $error("bypass position left sequencer active");
   a_bypass_supply: assert property (bypass |=> supply_on_out == $past(main_supply_input_in))
      else $error("bypass supply does not follow main supply");
   a_fail_flag: assert property (state == S_FAIL |-> power_fail_out && supply_on_out)
      else $error("power fail state not shown to host");
   a_fail_status: assert property (
      !bypass && !reset_in ##1 1 |-> power_fail_out == (state == S_FAIL))
      else $error("power fail status differs from state");
   a_deb_on_restart: assert property (state == S_DEB_ON && !control_in && !bypass |=> state == S_OFF)
      else $error("on debounce not restarted by glitch");
   a_deb_off_restart: assert property (
      state == S_DEB_OFF && control_in && !long_press && !bypass
      && !reserved && main_supply_input_in |=> state == S_RUN)
      else $error("off debounce not restarted by glitch");
   a_boot_supply: assert property (state == S_DEB_ON ##1 state == S_STARTUP |-> supply_on_out)
      else $error("supply not on after on debounce");
   a_startup_hold: assert property (
      $rose(state == S_RUN) |-> $past(state) inside {S_STARTUP, S_DEB_OFF})
      else $error("run entered without startup hold");
   a_long_press: assert property (
      long_press && state inside {S_STARTUP, S_RUN, S_DEB_OFF, S_FAIL} && main_supply_input_in
      |=> state == S_HARD_OFF && stop_out && !supply_on_out)
      else $error("long impulse did not hard-off");
   a_timeout_stop: assert property (
      state == S_FAIL && time_ms >= tim.hard_off && !host_shutdown_done_in
      && !bypass && !reserved && main_supply_input_in |=> stop_out)
      else $error("no stop after hard-off timeout");
   a_auto_start: assert property (
      state == S_OFF && auto_start && main_supply_input_in |=> state == S_STARTUP)
      else $error("auto start positions did not start");
   a_pulse_on: assert property (
      state == S_OFF && pulse_event && main_supply_input_in
      |=> state == S_STARTUP ##1 supply_on_out)
      else $error("impulse did not switch on");

   c_level_boot: cover property (state == S_DEB_ON ##1 state == S_STARTUP);
   c_power_fail: cover property (state == S_DEB_OFF ##1 state == S_FAIL);
   c_hard_off: cover property (state == S_FAIL ##1 state == S_HARD_OFF);
   c_clean_cut: cover property (state == S_FAIL ##1 state == S_CUT);

endmodule

// ===== rpos_sequencer_tb_top.sv
// rpos_sequencer_tb_top: self-checking bench of the remote power on/off sequencer
module rpos_sequencer_tb_top;
   import rpos_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // setup
   // ------------------------------------------------------------
   // a short prescaler keeps the run small; every window below except the fixed 800 us watchdog scales with it
   localparam int MC = 2;
   typedef struct {logic [2:0] v; int lo; int hi;} rpos_note_t;
   logic clock_in, reset_in, host_done, control, supply, s_on, p_fail, stop;
   logic [3:0] sw;
   logic [2:0] last;
   rpos_timing_t ut;
   int cyc, failures, n_checks;
   rpos_note_t exp_q[$];
   rpos_sequencer #(.MS_CYCLES(MC)) dut (.clock_in(clock_in), .reset_in(reset_in),
      .timing_select_switch_in(sw), .control_in(control), .main_supply_input_in(supply),
      .host_shutdown_done_in(host_done), .user_timing_in(ut), .supply_on_out(s_on),
      .power_fail_out(p_fail), .stop_out(stop));
   rpos_far_model far (.clock_in(clock_in), .control_out(control), .supply_out(supply));
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   always @(posedge clock_in) cyc <= cyc + 1;
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic mism(input string m);
      failures++;
      $display("mismatch at %0t: %s", $time, m);
   endtask
   task automatic end_sim();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // free-running tick: an interval may end up to one tick early per stage
   task automatic want(input logic [2:0] v, input int n_ms);
      int t0;
      t0 = cyc;
      exp_q.push_back('{v, t0 + (n_ms - 2) * MC - 2, t0 + n_ms * MC + 4});
      while (exp_q.size() != 0 && cyc < t0 + n_ms * MC + 8) @(posedge clock_in);
      if (exp_q.size() != 0) begin
         mism("expected output change missing");
         exp_q.delete();
      end
   endtask
   task automatic set_sw(input logic [3:0] v);
      @(posedge clock_in);
      sw <= v;
   endtask
   // any output change not announced by the driver is an error as well
   always @(negedge clock_in) begin
      if (!reset_in && {s_on, p_fail, stop} !== last) begin
         if (exp_q.size() == 0) mism("unexpected output change");
         else begin
            n_checks++;
            if (exp_q[0].v !== {s_on, p_fail, stop} || cyc < exp_q[0].lo || cyc > exp_q[0].hi)
               mism("output value or timing wrong");
            void'(exp_q.pop_front());
         end
      end
      last = {s_on, p_fail, stop};
   end
   task automatic user_walk(input logic done);
      logic [TW-1:0] d_on, d_off, st, ho;
      d_on = TW'(20 + $urandom_range(31));
      d_off = TW'(20 + $urandom_range(31));
      st = TW'(20 + $urandom_range(31));
      ho = TW'(20 + $urandom_range(31));
      @(posedge clock_in);
      ut <= '{d_on, d_off, st, ho};
      host_done <= done;
      far.level(1'b1);
      far.level(1'b0);
      far.level(1'b1);
      want(3'b100, int'(d_on));
      repeat (int'(st) * MC + 10) @(posedge clock_in);
      far.level(1'b0);
      far.level(1'b1);
      far.level(1'b0);
      want(3'b110, int'(d_off));
      want(done ? 3'b000 : 3'b001, int'(ho));
      if (!done) want(3'b000, 0);
      $display("test user walk done=%0b done", done);
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      reset_in = 1'b1;
      host_done = 1'b0;
      sw = POS_USER;
      ut = '0;
      cyc = 0;
      failures = 0;
      n_checks = 0;
      void'($urandom(32'hfaf5ad37));
      repeat (3) @(posedge clock_in);
      reset_in <= 1'b0;
      user_walk(1'b0);
      user_walk(1'b1);
      set_sw(4'hb + 4'($urandom_range(4)));
      set_sw(4'h4);
      far.level(1'b1);
      want(3'b100, 1000);
      repeat (3000 * MC) @(posedge clock_in);
      far.level(1'b0);
      want(3'b110, 7000);
      set_sw(4'hb + 4'($urandom_range(4)));
      want(3'b000, 0);
      $display("test fixed timings done");
      set_sw(4'h6);
      want(3'b100, 0);
      far.supply(1'b0);
      want(3'b000, 0);
      set_sw(4'h7);
      far.supply(1'b1);
      far.pulse(200 * MC);
      repeat (10) @(posedge clock_in);
      far.pulse(300 * MC);
      want(3'b100, 0);
      set_sw(4'h9);
      far.level(1'b1);
      want(3'b001, 5000);
      far.level(1'b0);
      want(3'b000, 0);
      $display("test pulse modes done");
      set_sw(POS_BYPASS);
      want(3'b110, 0);
      far.level(1'b1);
      want(3'b100, 0);
      far.supply(1'b0);
      want(3'b000, 0);
      $display("test bypass done");
      end_sim();
   end
   initial begin
      #800us;
      mism("watchdog expired");
      end_sim();
   end
endmodule
